// File: hdl/ptmr_top.sv
/*
 * 8-bit up-counting auto-reload timer with single-channel PWM, reached
 * over an Avalon-MM slave with one wait state.
 * Assumes the instruction and oscillator ticks and the GPIO drive come
 * from logic on clk; bus master follows Avalon waitrequest signalling.
 */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_defines.svh"

module ptmr_top
    import ptmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic instr_clk_tick,
    input wire logic hosc_tick,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pwm_shared_pin_out,
    output logic pwm_shared_pin_oe,
    output logic irq_request
);
    ptmr_top_state_t st_r;
    ptmr_top_state_t st_nxt;

    logic [7:0] reg_idx;
    logic access_ok;
    logic wr_mode;
    logic wr_count;
    logic wr_reload;
    logic wr_duty;
    logic wr_status;
    logic [7:0] wbyte;
    logic timer_enable_bit;
    logic clock_source_select;
    logic [2:0] prescaler_select;
    logic pwm_pin_enable;
    logic tick;
    logic step;
    logic overflow;
    logic start;
    logic [7:0] count_step;
    logic [7:0] reload_act_nxt;
    logic pwm_level;
    logic [7:0] read_mux;

    // mode register fields
    assign timer_enable_bit = st_r.mode[`PTMR_MODE_EN_BIT];
    assign clock_source_select = st_r.mode[`PTMR_MODE_CKS_BIT];
    assign prescaler_select =
        st_r.mode[`PTMR_MODE_RATE_HI:`PTMR_MODE_RATE_LO];
    assign pwm_pin_enable = st_r.mode[`PTMR_MODE_PWM_BIT];

    ptmr_tick_gen u_tick (
        .clk(clk),
        .reset(reset),
        .run(timer_enable_bit),
        .source_hosc(clock_source_select),
        .rate(prescaler_select),
        .instr_tick(instr_clk_tick),
        .hosc_tick(hosc_tick),
        .tick(tick)
    );

    // bus decode: a request is taken only in its second cycle, when the
    // registered waitrequest has dropped; the first cycle loads read data
    assign reg_idx = avs_address[9:2];
    assign access_ok = avs_write && st_r.wait_n && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_mode = access_ok && (reg_idx == `PTMR_IDX_MODE);
    assign wr_count = access_ok && (reg_idx == `PTMR_IDX_COUNT);
    assign wr_reload = access_ok && (reg_idx == `PTMR_IDX_RELOAD);
    assign wr_duty = access_ok && (reg_idx == `PTMR_IDX_DUTY);
    assign wr_status = access_ok && (reg_idx == `PTMR_IDX_STATUS);

    // counter stepping; nothing here looks at a low-power mode, so the
    // timer keeps counting and flagging in green mode, and the block has
    // no wake-up output at all
    assign step = timer_enable_bit && tick;
    assign overflow = step && (st_r.count == `PTMR_FULL_SCALE);
    assign count_step = st_r.count + 8'h01;

    // holding buffer moves to the active reload only at overflow; the
    // reload path has no switch of its own
    assign reload_act_nxt = overflow ? st_r.reload_hold
                                     : st_r.reload_act;

    // a fresh enable starts a PWM cycle from the preloaded counter
    assign start = timer_enable_bit && !st_r.enable_d;

    ptmr_pwm_out u_pwm (
        .clk(clk),
        .reset(reset),
        .start(start),
        .overflow(overflow),
        .step(step),
        .count_nxt(st_nxt.count),
        .duty(st_r.duty),
        .reload_nxt(reload_act_nxt),
        .level(pwm_level)
    );

    // read data mux; reload is write-only and reserved bits read zero
    always_comb begin
        read_mux = 8'h00;
        unique case (reg_idx)
            `PTMR_IDX_MODE: begin
                read_mux = st_r.mode;
            end
            `PTMR_IDX_COUNT: begin
                read_mux = st_r.count;
            end
            `PTMR_IDX_DUTY: begin
                read_mux = st_r.duty;
            end
            `PTMR_IDX_STATUS: begin
                read_mux = 8'h00;
                read_mux[`PTMR_STAT_FLAG_BIT] = st_r.flag;
                read_mux[`PTMR_STAT_IEN_BIT] = st_r.ien;
            end
            default: begin
                read_mux = 8'h00;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;

        // one wait state for every access, reads and writes alike
        if ((avs_read || avs_write) && !st_r.wait_n) begin
            st_nxt.wait_n = 1'b1;
            st_nxt.rdata = avs_read ? read_mux : 8'h00;
        end else begin
            st_nxt.wait_n = 1'b0;
        end

        if (wr_mode) begin
            st_nxt.mode = wbyte & `PTMR_MODE_WMASK;
        end

        // software write to the counter wins over a tick in the same cycle
        if (wr_count) begin
            st_nxt.count = wbyte;
        end else if (overflow) begin
            st_nxt.count = st_r.reload_hold;
        end else if (step) begin
            st_nxt.count = count_step;
        end

        if (wr_reload) begin
            st_nxt.reload_hold = wbyte;
        end
        st_nxt.reload_act = reload_act_nxt;

        if (wr_duty) begin
            st_nxt.duty = wbyte;
        end

        if (wr_status) begin
            st_nxt.ien = wbyte[`PTMR_STAT_IEN_BIT];
            // writing zero clears the flag; writing one leaves it alone
            if (!wbyte[`PTMR_STAT_FLAG_BIT]) begin
                st_nxt.flag = 1'b0;
            end
        end
        // an overflow in the clearing cycle is kept: set wins
        if (overflow) begin
            st_nxt.flag = 1'b1;
        end

        st_nxt.enable_d = timer_enable_bit;

        // request follows flag and enable; PWM use does not mask it
        st_nxt.irq = st_nxt.flag && st_nxt.ien;

        // pin handover: GPIO drive passes through untouched while the
        // PWM bit is clear, so the old GPIO state returns on clearing
        if (pwm_pin_enable) begin
            st_nxt.pin_out = pwm_level;
            st_nxt.pin_oe = 1'b1;
        end else begin
            st_nxt.pin_out = gpio_out;
            st_nxt.pin_oe = gpio_oe;
        end
    end

    // PWM period is 256 minus reload counts because overflow reloads the
    // counter and restarts the cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = {24'h000000, st_r.rdata};
    assign avs_waitrequest = !st_r.wait_n;
    assign pwm_shared_pin_out = st_r.pin_out;
    assign pwm_shared_pin_oe = st_r.pin_oe;
    assign irq_request = st_r.irq;
endmodule
`default_nettype wire

// File: hdl/ptmr_defines.svh
/*
 * Register indices, field positions, reset values and clocking constants
 * for the 8-bit auto-reload PWM timer.
 * Assumes it is included by its bare name wherever these macros are used.
 */
// Function
// - counter advances only while the mode register enable bit is one.
// - counter increments per selected tick; overflow is 0xff stepping to 0x00.
// - overflow sets the overflow flag; only a software write clears it.
// - every overflow reloads the counter from the active reload value.
// - reload writes go to a holding buffer, moved to active at overflow.
// - auto-reload always works while enabled; no control bit disables it.
// - with interrupt enable set, each overflow raises an interrupt request.
// - in green mode timer keeps counting, flagging, driving PWM; never wakes.
// - clock-source bit one selects undivided oscillator, ignoring prescaler.
// - prescaler field 000 divides by 128, halving per step, 111 by 1.
// - PWM enable bit drives shared pin with PWM; clearing returns GPIO.
// - each PWM cycle starts high, goes low when counter equals duty.
// - at each overflow the PWM cycle ends and output returns high.
// - PWM period is 256 minus reload value counts.
// - duty not greater than reload keeps PWM low for the whole cycle.
// - with PWM active, overflow flag and interrupt still work normally.
`ifndef PTMR_DEFINES_SVH
`define PTMR_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define PTMR_IDX_MODE 8'hdc
`define PTMR_IDX_COUNT 8'hdd
`define PTMR_IDX_RELOAD 8'hde
`define PTMR_IDX_DUTY 8'hea
`define PTMR_IDX_STATUS 8'heb

// mode register fields
`define PTMR_MODE_EN_BIT 7
`define PTMR_MODE_RATE_HI 6
`define PTMR_MODE_RATE_LO 4
`define PTMR_MODE_CKS_BIT 2
`define PTMR_MODE_PWM_BIT 0
`define PTMR_MODE_WMASK 8'hf5

// status register fields
`define PTMR_STAT_FLAG_BIT 0
`define PTMR_STAT_IEN_BIT 1

`define PTMR_RST_BYTE 8'h00
`define PTMR_FULL_SCALE 8'hff
`define PTMR_PRESCALE_W 7

`endif

// File: hdl/ptmr_pkg.sv
/*
 * Types shared by the PWM timer modules: the packed state of each module.
 * Assumes the defines header is compiled alongside.
 */
package ptmr_pkg;

    typedef struct packed {
        logic [6:0] cnt;
    } ptmr_prescale_state_t;

    typedef struct packed {
        logic level;
    } ptmr_pwm_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] count;
        logic [7:0] reload_hold;
        logic [7:0] reload_act;
        logic [7:0] duty;
        logic flag;
        logic ien;
        logic enable_d;
        logic wait_n;
        logic [7:0] rdata;
        logic irq;
        logic pin_out;
        logic pin_oe;
    } ptmr_top_state_t;

endpackage

// File: hdl/ptmr_tick_gen.sv
/*
 * Timer tick generator: instruction-clock prescaler or raw oscillator tick.
 * Assumes both tick inputs are one-cycle strobes on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_defines.svh"

module ptmr_tick_gen
    import ptmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic source_hosc,
    input wire logic [2:0] rate,
    input wire logic instr_tick,
    input wire logic hosc_tick,
    output logic tick
);
    ptmr_prescale_state_t st_r;
    ptmr_prescale_state_t st_nxt;
    logic [6:0] mask;

    always_comb begin
        // rate 0 keeps all seven bits -> /128, rate 7 keeps none -> /1
        mask = 7'h7f >> rate;
        st_nxt = st_r;
        tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = 7'h00;
        end else if (source_hosc) begin
            tick = hosc_tick;
        end else if (instr_tick) begin
            st_nxt.cnt = st_r.cnt + 7'h01;
            tick = ((st_r.cnt & mask) == mask);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// File: hdl/ptmr_pwm_out.sv
/*
 * PWM level generator driven by the timer's counter and overflow events.
 * Assumes counter and events come from the timer core on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_defines.svh"

module ptmr_pwm_out
    import ptmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic overflow,
    input wire logic step,
    input wire logic [7:0] count_nxt,
    input wire logic [7:0] duty,
    input wire logic [7:0] reload_nxt,
    output logic level
);
    ptmr_pwm_state_t st_r;
    ptmr_pwm_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (start || overflow) begin
            // new cycle high, unless duty can never be reached
            st_nxt.level = (duty > reload_nxt);
        end else if (step && (count_nxt == duty)) begin
            st_nxt.level = 1'b0;
        end
        level = st_r.level;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// File: verification/ptmr_properties.sv
/* port-level assertions for the PWM timer top level
   assumes a bind onto ptmr_top, a single clock domain */
`timescale 1ns/1ps
`default_nettype none
module ptmr_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic gpio_oe,
    input wire logic pwm_shared_pin_oe,
    input wire logic irq_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_ack_after_wait: assert property (s_req |=> s_ack)
        else $error("no single-cycle acknowledge after request");
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge held too long");
    a_ack_needs_req: assert property ($fell(avs_waitrequest)
        |-> $past(avs_read) || $past(avs_write))
        else $error("acknowledge without request");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_idle_waits: assert property ((!avs_read && !avs_write)[*2]
        |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    a_reset_quiet: assert property ($past(reset) |-> avs_waitrequest &&
        !irq_request && !pwm_shared_pin_oe)
        else $error("outputs not quiet after reset");
    a_gpio_oe_follow: assert property (
        !pwm_shared_pin_oe && !$past(reset) |-> !$past(gpio_oe))
        else $error("pin released while gpio drives");
    a_irq_clear_cause: assert property ($fell(irq_request)
        |-> $past(avs_write) || $past(avs_write, 2))
        else $error("interrupt dropped without a write");
endmodule

bind ptmr_top ptmr_properties u_props (.clk(clk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gpio_oe(gpio_oe), .pwm_shared_pin_oe(pwm_shared_pin_oe),
    .irq_request(irq_request));
`default_nettype wire

// File: verification/ptmr_top_tb_top.sv
/* self-checking bench for the PWM timer top level
   assumes the package and the design files are compiled first */
`timescale 1ns/1ps
`default_nettype none
module ptmr_top_tb_top import ptmr_pkg::*;;
    logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0] avs_address = 10'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, instr_clk_tick = 1'b0, hosc_tick = 1'b0;
    logic gpio_out = 1'b0, gpio_oe = 1'b0;
    logic pwm_shared_pin_out, pwm_shared_pin_oe, irq_request;
    logic [7:0] ix[6] = '{8'hdc, 8'hdd, 8'hde, 8'hea, 8'heb, 8'h10};
    logic [31:0] exp_q[$];
    int n_errors = 0, num_checks = 0, r;
    always #5 clk = ~clk;
    ptmr_top DUT (.clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .instr_clk_tick, .hosc_tick, .gpio_out, .gpio_oe,
        .pwm_shared_pin_out, .pwm_shared_pin_oe, .irq_request);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a read passes its expected byte as d; the monitor compares it
    task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        if (!wr) exp_q.push_back({24'h0, d});
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", exp_q.pop_front(), avs_readdata);
    // instruction ticks always pulse, so a raw-oscillator mode shows it
    task automatic tk(int n, logic hs);
        repeat (n) begin
            @(posedge clk);
            instr_clk_tick <= 1'b1;
            hosc_tick <= hs;
            @(posedge clk);
            instr_clk_tick <= 1'b0;
            hosc_tick <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic pwm_seq(logic [7:0] pat, int n);
        for (int i = n - 1; i >= 0; i--) begin
            tk(1, 1'b0);
            chk("pin_out", pat[i], pwm_shared_pin_out);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200_000;
        n_errors++;
        conclude();
    end
    initial begin
        r = $urandom(32303);
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        foreach (ix[i]) bus(0, ix[i], 8'h00);
        repeat (4) begin
            r = $urandom;
            bus(1, 8'hea, r[7:0]);
            bus(0, 8'hea, r[7:0]);
            bus(1, 8'hde, r[15:8]);
            bus(0, 8'hde, 8'h00);
        end
        // a write with the low byte lane disabled must leave duty alone
        avs_byteenable <= 4'he;
        bus(1, 8'hea, ~r[7:0]);
        avs_byteenable <= 4'hf;
        bus(0, 8'hea, r[7:0]);
        bus(1, 8'hdc, 8'h7a);
        bus(0, 8'hdc, 8'h70);
        for (int k = 0; k < 8; k++) begin
            bus(1, 8'hdd, 8'h00);
            bus(1, 8'hdc, {1'b1, k[2:0], 4'h0});
            tk(128, 1'b0);
            bus(1, 8'hdc, 8'h00);
            bus(0, 8'hdd, 8'd128 >> (7 - k));
        end
        bus(1, 8'hdd, 8'h00);
        bus(1, 8'hdc, 8'hf4);
        tk(5, 1'b0);
        tk(3, 1'b1);
        bus(0, 8'hdd, 8'h03);
        bus(1, 8'hdc, 8'h00);
        bus(1, 8'hdd, 8'hfd);
        bus(1, 8'hde, 8'hfd);
        bus(1, 8'heb, 8'h02);
        bus(1, 8'hdc, 8'hf0);
        tk(2, 1'b0);
        bus(1, 8'hde, 8'h10);
        bus(0, 8'hdd, 8'hff);
        bus(0, 8'heb, 8'h02);
        tk(1, 1'b0);
        bus(0, 8'hdd, 8'h10);
        bus(0, 8'heb, 8'h03);
        chk("irq", 1'b1, irq_request);
        bus(1, 8'heb, 8'h02);
        bus(0, 8'heb, 8'h02);
        chk("irq", 1'b0, irq_request);
        bus(1, 8'hdc, 8'h00);
        tk(2, 1'b0);
        bus(0, 8'hdd, 8'h10);
        bus(1, 8'hdd, 8'hfc);
        bus(1, 8'hde, 8'hfc);
        bus(1, 8'hea, 8'hfe);
        bus(1, 8'hdc, 8'hf1);
        tk(0, 1'b0);
        chk("pin_oe", 1'b1, pwm_shared_pin_oe);
        // restarted level reaches the pin register two edges after start
        @(posedge clk);
        chk("pin_out", 1'b1, pwm_shared_pin_out);
        pwm_seq(8'h09, 4);
        bus(1, 8'hea, 8'hfc);
        pwm_seq(8'he0, 8);
        bus(0, 8'heb, 8'h03);
        chk("irq", 1'b1, irq_request);
        {gpio_oe, gpio_out} <= r[17:16];
        bus(1, 8'hdc, 8'h80);
        tk(0, 1'b0);
        chk("pin_out", gpio_out, pwm_shared_pin_out);
        chk("pin_oe", gpio_oe, pwm_shared_pin_oe);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(1, 8'hdd, 8'hff);
        bus(1, 8'hdc, 8'hf0);
        tk(1, 1'b0);
        bus(0, 8'hdd, 8'h00);
        chk("pin_oe", gpio_oe, pwm_shared_pin_oe);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
